// [hw/pct_timer.sv]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pct_timer
  import pct_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        carrier_tick,
  input  wire logic        tx_end_evt,
  input  wire logic        rx_first_bit_evt,
  input  wire logic        gate_input_a,
  input  wire logic        gate_input_b,
  output logic             counting_active_flag,
  output logic             countdown_expired_flag,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Word index from a byte address; low two bits ignored
  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction

  // True for any index the block answers with OKAY
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= IDX_MODE && idx <= IDX_CNT_LO) ||
                idx == IDX_CTRL || idx == IDX_STAT;
  endfunction

  logic [7:0]  mode_reg;        // Timer mode control
  logic [7:0]  presc_reg;       // Prescale low byte
  logic [7:0]  rld_hi;          // Reload upper byte
  logic [7:0]  rld_lo;          // Reload lower byte
  logic        multi_frame_receive;  // Keep running through reception
  logic        sw_start;        // Software start pulse
  logic        sw_stop;         // Immediate stop pulse
  logic [15:0] current_count;   // Live count
  logic [11:0] pre_cnt;         // Prescale down counter
  pct_state_t  state;           // Timer state
  pct_state_t  next_state;      // Next timer state
  logic [1:0]  gate_a_sync;     // Pin synchroniser, first gate
  logic [1:0]  gate_b_sync;     // Pin synchroniser, second gate
  logic        aw_held;         // Write address captured
  logic        w_held;          // Write data captured
  logic [5:0]  aw_idx;          // Captured write index
  logic [31:0] w_data;          // Captured write data
  logic [3:0]  w_strb;          // Captured byte enables
  logic        do_write;        // Both halves present, commit now
  logic [31:0] rd_word;         // Read mux result

  // Mode fields
  logic        auto_start_on_tx;
  logic [1:0]  gate_select;
  logic        reload_on_expiry;
  logic [11:0] prescale_value;
  logic [15:0] reload_value;
  assign auto_start_on_tx = mode_reg[MODE_AUTO_BIT];
  assign gate_select      = mode_reg[MODE_GATE_HI:MODE_GATE_LO];
  assign reload_on_expiry = mode_reg[MODE_RESTART_BIT];
  assign prescale_value   = {mode_reg[MODE_PSC_HI:0], presc_reg};
  assign reload_value     = {rld_hi, rld_lo};

  // Gate pins cross from outside; two flops before any use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_a_sync <= 2'h0;
      gate_b_sync <= 2'h0;
    end else begin
      gate_a_sync <= {gate_a_sync[0], gate_input_a};
      gate_b_sync <= {gate_b_sync[0], gate_input_b};
    end
  end

  // Gate level for the selected source; code 11 behaves as free running
  logic gate_open;
  always_comb begin
    case (gate_select)
      GATE_NONE: gate_open = 1'b1;
      GATE_A:    gate_open = gate_a_sync[1];
      GATE_B:    gate_open = gate_b_sync[1];
      default:   gate_open = 1'b1;
    endcase
  end

  // Start and stop causes; protocol events count only with auto start
  logic start_evt;
  logic stop_evt;
  logic tick;
  logic psc_end;
  logic at_end;
  logic expire_evt;
  logic restart_evt;
  assign start_evt = sw_start | (auto_start_on_tx & tx_end_evt);
  assign stop_evt  = sw_stop |
                     (auto_start_on_tx & ~multi_frame_receive &
                      rx_first_bit_evt);
  // Carrier ticks pass only while running and the gate is open
  assign tick    = (state == TM_RUN) & carrier_tick & gate_open;
  assign psc_end = tick & (pre_cnt == PSC_ZERO);
  assign at_end  = psc_end & (current_count <= COUNT_ONE);
  assign expire_evt  = at_end & ~reload_on_expiry & ~start_evt & ~stop_evt;
  assign restart_evt = at_end & reload_on_expiry & ~start_evt & ~stop_evt;

  // Next state; a stop in the same cycle as a start wins
  always_comb begin
    case (state)
      TM_IDLE: next_state = (start_evt & ~stop_evt) ? TM_RUN : TM_IDLE;
      TM_RUN:  next_state = (stop_evt | expire_evt) ? TM_IDLE : TM_RUN;
      default: next_state = TM_IDLE;
    endcase
  end

  // State and its mirror flag; the flag ignores the gate level
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state                <= TM_IDLE;
      counting_active_flag <= 1'b0;
    end else begin
      state                <= next_state;
      counting_active_flag <= (next_state == TM_RUN);
    end
  end

  // Count and prescale; reload is sampled at a start and at a restart expiry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      current_count <= COUNT_RST;
      pre_cnt       <= PSC_ZERO;
    end else if (start_evt & ~stop_evt) begin
      current_count <= reload_value;
      pre_cnt       <= prescale_value;
    end else if (tick & ~stop_evt) begin
      if (pre_cnt == PSC_ZERO) begin
        pre_cnt <= prescale_value;
        // Restart reloads, one-shot parks at zero, otherwise step down
        current_count <= restart_evt ? reload_value :
                         at_end      ? COUNT_RST    :
                         current_count - COUNT_ONE;
      end else begin
        pre_cnt <= pre_cnt - 12'h001;
      end
    end
  end

  // Expired flag; a new expiry beats a write-one clear
  logic clr_expired;
  assign clr_expired = do_write & (aw_idx == IDX_STAT) & w_strb[0] &
                       w_data[STAT_EXP_BIT];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      countdown_expired_flag <= 1'b0;
    end else if (expire_evt) begin
      countdown_expired_flag <= 1'b1;
    end else if (clr_expired) begin
      countdown_expired_flag <= 1'b0;
    end
  end

  // Write address and data channels, taken in either order
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 6'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_idx        <= reg_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      // Only one write in flight; ready returns once the response is accepted
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes; only byte lane 0 carries data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_reg            <= MODE_RST;
      presc_reg           <= PRESC_RST;
      rld_hi              <= RLD_RST;
      rld_lo              <= RLD_RST;
      multi_frame_receive <= 1'b0;
    end else if (do_write & w_strb[0]) begin
      case (aw_idx)
        IDX_MODE:   mode_reg  <= w_data[7:0];
        IDX_PRESC:  presc_reg <= w_data[7:0];
        IDX_RLD_HI: rld_hi    <= w_data[7:0];
        IDX_RLD_LO: rld_lo    <= w_data[7:0];
        IDX_CTRL:   multi_frame_receive <= w_data[CTRL_MULTI_BIT];
        default:    mode_reg  <= mode_reg;
      endcase
    end
  end

  // Command pulses, one cycle each, from control writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_start <= 1'b0;
      sw_stop  <= 1'b0;
    end else begin
      sw_start <= do_write & w_strb[0] & (aw_idx == IDX_CTRL) &
                  w_data[CTRL_START_BIT];
      sw_stop  <= do_write & w_strb[0] & (aw_idx == IDX_CTRL) &
                  w_data[CTRL_STOP_BIT];
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_index(s_axi_araddr))
      IDX_MODE:   rd_word[7:0] = mode_reg;
      IDX_PRESC:  rd_word[7:0] = presc_reg;
      IDX_RLD_HI: rd_word[7:0] = rld_hi;
      IDX_RLD_LO: rd_word[7:0] = rld_lo;
      IDX_CNT_HI: rd_word[7:0] = current_count[15:8];
      IDX_CNT_LO: rd_word[7:0] = current_count[7:0];
      IDX_CTRL:   rd_word[CTRL_MULTI_BIT] = multi_frame_receive;
      IDX_STAT: begin
        rd_word[STAT_RUN_BIT] = counting_active_flag;
        rd_word[STAT_EXP_BIT] = countdown_expired_flag;
      end
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel; data captured at the address handshake
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= is_mapped(reg_index(s_axi_araddr)) ?
                       RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Checks on the timer behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_auto_start;
    auto_start_on_tx && tx_end_evt && !stop_evt |=> counting_active_flag;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("auto start missed");

  property p_rx_stop;
    state == TM_RUN && auto_start_on_tx && !multi_frame_receive &&
    rx_first_bit_evt |=> !counting_active_flag;
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("first rx bit did not stop");

  property p_multi_run;
    state == TM_RUN && auto_start_on_tx && multi_frame_receive &&
    rx_first_bit_evt && !sw_stop && !expire_evt |=> counting_active_flag;
  endproperty
  a_multi_run: assert property (p_multi_run)
    else $error("multi frame timer stopped");

  property p_no_auto;
    !auto_start_on_tx && tx_end_evt && state == TM_IDLE && !sw_start
    |=> !counting_active_flag;
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("protocol started timer");

  property p_gate_hold;
    state == TM_RUN && gate_select == GATE_A && !gate_a_sync[1] && !start_evt
    |=> $stable(current_count) && counting_active_flag != $past(stop_evt);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("count moved while gated");

  property p_restart;
    restart_evt |=> current_count == $past(reload_value) &&
                    counting_active_flag;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not reload");

  property p_expire;
    expire_evt |=> countdown_expired_flag && !counting_active_flag &&
                   current_count == COUNT_RST;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry not flagged");

  property p_load;
    start_evt && !stop_evt |=> current_count == $past(reload_value) &&
                               pre_cnt == $past(prescale_value);
  endproperty
  a_load: assert property (p_load)
    else $error("start did not load");

  property p_prescale;
    tick && pre_cnt != PSC_ZERO && !start_evt && !stop_evt
    |=> pre_cnt == $past(pre_cnt) - 12'h001 && $stable(current_count);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler step wrong");

  c_expire: cover property (expire_evt);
  c_restart: cover property (restart_evt);
  c_rx_stop: cover property (state == TM_RUN && rx_first_bit_evt);

endmodule

// [hw/pct_pkg.sv]
// Shared constants for the protocol aware countdown timer
package pct_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE   = 6'h2a;  // Timer mode control
  localparam logic [5:0] IDX_PRESC  = 6'h2b;  // Prescale low byte
  localparam logic [5:0] IDX_RLD_HI = 6'h2c;  // Reload high byte
  localparam logic [5:0] IDX_RLD_LO = 6'h2d;  // Reload low byte
  localparam logic [5:0] IDX_CNT_HI = 6'h2e;  // Live count high byte
  localparam logic [5:0] IDX_CNT_LO = 6'h2f;  // Live count low byte
  localparam logic [5:0] IDX_CTRL   = 6'h38;  // Command and receive setup
  localparam logic [5:0] IDX_STAT   = 6'h39;  // Running and expiry status

  // Mode register fields
  localparam int MODE_AUTO_BIT    = 7;  // Auto start on transmit end
  localparam int MODE_GATE_HI     = 6;  // Gate select upper bit
  localparam int MODE_GATE_LO     = 5;  // Gate select lower bit
  localparam int MODE_RESTART_BIT = 4;  // Reload on expiry
  localparam int MODE_PSC_HI      = 3;  // Top of prescale upper nibble

  // Gate select codes
  localparam logic [1:0] GATE_NONE = 2'h0;  // Free running
  localparam logic [1:0] GATE_A    = 2'h1;  // Gated by first pin
  localparam logic [1:0] GATE_B    = 2'h2;  // Gated by second pin

  // Control register bits
  localparam int CTRL_STOP_BIT  = 0;  // Write 1: immediate stop
  localparam int CTRL_START_BIT = 1;  // Write 1: software start
  localparam int CTRL_MULTI_BIT = 2;  // Stored: multi frame receive

  // Status register bits
  localparam int STAT_RUN_BIT = 0;  // Counting active
  localparam int STAT_EXP_BIT = 1;  // Expired, write 1 to clear

  // Reset values and count constants
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [7:0]  PRESC_RST = 8'h00;
  localparam logic [7:0]  RLD_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [11:0] PSC_ZERO  = 12'h000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timer state, Gray coded
  typedef enum logic [1:0] {
    TM_IDLE = 2'b00,
    TM_RUN  = 2'b01
  } pct_state_t;

endpackage

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import pct_pkg::*;

  logic        clock;                   // 10 MHz system clock
  logic        rstn;                    // Active low reset
  logic        carrier_tick;            // Prescaler enable pulse
  logic        tx_end_evt;              // End of transmission pulse
  logic        rx_first_bit_evt;        // First received bit pulse
  logic        gate_input_a;            // First gate pin
  logic        gate_input_b;            // Second gate pin
  logic        counting_active_flag;    // Running status
  logic        countdown_expired_flag;  // Sticky expiry
  logic [7:0]  awaddr, araddr;          // Byte addresses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;            // Data channels
  logic [3:0]  wstrb;                   // Byte strobes
  logic [1:0]  bresp, rresp;            // Responses
  int          fail_count;              // Mismatches seen
  int          n_compared;              // Comparisons made
  int          cycles;                  // Watchdog count
  logic [1:0]  resp;                    // Scratch response
  logic [31:0] rd;                      // Scratch read data

  pct_timer u_dut (
    .clock(clock), .rstn(rstn), .carrier_tick(carrier_tick),
    .tx_end_evt(tx_end_evt), .rx_first_bit_evt(rx_first_bit_evt),
    .gate_input_a(gate_input_a), .gate_input_b(gate_input_b),
    .counting_active_flag(counting_active_flag),
    .countdown_expired_flag(countdown_expired_flag),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // Free running clock, half period 50 ns
  always #50 clock = ~clock;

  // Watchdog: the whole script needs fewer than two thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  // Single comparison point; case equality so unknowns never match
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // AXI write: AW and W offered together, each dropped when taken
  task automatic bus_write(input logic [5:0] idx, input logic [7:0] d,
                           output logic [1:0] r);
    @(posedge clock);
    awaddr  <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'h1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // AXI read: rready held until the data beat arrives
  task automatic bus_read(input logic [5:0] idx, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clock);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Write expecting an OKAY response
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [1:0] r;
    bus_write(idx, d, r);
    check("bresp", 32'(r), 32'(RESP_OKAY));
  endtask

  // Read a register and compare the whole word with the byte zero extended
  task automatic expect_reg(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    bus_read(idx, d, r);
    check("rresp", 32'(r), 32'(RESP_OKAY));
    check("register", d, {24'h000000, e});
  endtask

  // Live count is only stable while ticks are held off
  task automatic expect_count(input logic [15:0] e);
    expect_reg(IDX_CNT_HI, e[15:8]);
    expect_reg(IDX_CNT_LO, e[7:0]);
  endtask

  // carrier tick held high for n consecutive cycles, then let the flags settle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      carrier_tick <= 1'b1;
    end
    @(posedge clock);
    carrier_tick <= 1'b0;
    idle(2);
  endtask

  // Protocol event pulse: tx end when sel is 0, first rx bit otherwise
  task automatic pulse(input bit sel);
    @(posedge clock);
    if (sel) rx_first_bit_evt <= 1'b1;
    else tx_end_evt <= 1'b1;
    @(posedge clock);
    rx_first_bit_evt <= 1'b0;
    tx_end_evt <= 1'b0;
    idle(2);
  endtask

  task automatic expect_run(input logic e);
    check("running", 32'(counting_active_flag), 32'(e));
  endtask

  // Software start (control bit 1) and immediate stop (bit 0)
  task automatic start_t();
    wr(IDX_CTRL, 8'h02);
    idle(2);
  endtask

  task automatic stop_t();
    wr(IDX_CTRL, 8'h01);
    idle(2);
  endtask

  initial begin
    clock = 1'b0; rstn = 1'b0; carrier_tick = 1'b0;
    tx_end_evt = 1'b0; rx_first_bit_evt = 1'b0;
    gate_input_a = 1'b1; gate_input_b = 1'b1;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0;
    rready = 1'b0; fail_count = 0; n_compared = 0; cycles = 0;
    idle(3);
    rstn <= 1'b1;
    // Reset values of the mode, prescale and two reload registers
    for (int i = 0; i < 4; i++) expect_reg(6'(IDX_MODE + i), 8'h00);
    // Unmapped index is refused on both paths
    bus_write(6'h00, 8'h5a, resp);
    check("bresp unmapped", 32'(resp), 32'(RESP_SLVERR));
    bus_read(6'h00, rd, resp);
    check("rresp unmapped", 32'(resp), 32'(RESP_SLVERR));
    // Prescale 0x102 splits over nibble and byte; reload 0x0105
    wr(IDX_MODE, 8'h01);
    wr(IDX_PRESC, 8'h02);
    wr(IDX_RLD_HI, 8'h01);
    wr(IDX_RLD_LO, 8'h05);
    expect_reg(IDX_MODE, 8'h01);
    expect_reg(IDX_PRESC, 8'h02);
    expect_reg(IDX_RLD_HI, 8'h01);
    expect_reg(IDX_RLD_LO, 8'h05);
    start_t();
    expect_run(1'b1);
    expect_count(16'h0105);
    // 259 carrier ticks per decrement
    tick(518);
    expect_count(16'h0103);
    tick(258);
    expect_count(16'h0103);
    tick(1);
    expect_count(16'h0102);
    // Reload write mid-count waits for the next start
    wr(IDX_RLD_LO, 8'h20);
    expect_count(16'h0102);
    stop_t();
    expect_run(1'b0);
    start_t();
    expect_count(16'h0120);
    // One-shot expiry with prescale 0
    wr(IDX_MODE, 8'h00);
    wr(IDX_PRESC, 8'h00);
    wr(IDX_RLD_HI, 8'h00);
    wr(IDX_RLD_LO, 8'h03);
    start_t();
    tick(2);
    expect_run(1'b1);
    expect_count(16'h0001);
    tick(1);
    expect_run(1'b0);
    check("expired", 32'(countdown_expired_flag), 32'h1);
    expect_count(16'h0000);
    expect_reg(IDX_STAT, 8'h02);
    wr(IDX_STAT, 8'h02);
    idle(2);
    check("expired clr", 32'(countdown_expired_flag), 32'h0);
    // Restart mode: reload and keep running, no expiry flag
    wr(IDX_MODE, 8'h10);
    start_t();
    tick(3);
    expect_run(1'b1);
    expect_count(16'h0003);
    check("expired", 32'(countdown_expired_flag), 32'h0);
    stop_t();
    // Auto start, single frame: first rx bit stops
    wr(IDX_MODE, 8'h80);
    wr(IDX_CTRL, 8'h00);
    pulse(1'b0);
    expect_run(1'b1);
    expect_count(16'h0003);
    tick(1);
    pulse(1'b1);
    expect_run(1'b0);
    expect_count(16'h0002);
    // Multi frame: rx ignored, the stop command halts
    wr(IDX_CTRL, 8'h04);
    pulse(1'b0);
    pulse(1'b1);
    expect_run(1'b1);
    wr(IDX_CTRL, 8'h05);
    idle(2);
    expect_run(1'b0);
    // Auto off: protocol events have no effect
    wr(IDX_MODE, 8'h00);
    wr(IDX_CTRL, 8'h00);
    pulse(1'b0);
    expect_run(1'b0);
    start_t();
    pulse(1'b1);
    expect_run(1'b1);
    stop_t();
    // Gate A closed, B open: count holds, status still running
    wr(IDX_MODE, 8'h20);
    gate_input_a <= 1'b0;
    start_t();
    idle(4);
    tick(5);
    expect_count(16'h0003);
    expect_run(1'b1);
    gate_input_a <= 1'b1;
    gate_input_b <= 1'b0;
    idle(4);
    tick(1);
    expect_count(16'h0002);
    // Gate B selected: only its level matters
    wr(IDX_MODE, 8'h40);
    start_t();
    tick(5);
    expect_count(16'h0003);
    expect_run(1'b1);
    gate_input_a <= 1'b0;
    gate_input_b <= 1'b1;
    idle(4);
    tick(1);
    expect_count(16'h0002);
    // Ungated: both pins closed, count still moves
    wr(IDX_MODE, 8'h00);
    gate_input_b <= 1'b0;
    start_t();
    idle(4);
    tick(1);
    expect_count(16'h0002);
    // Undefined code 11 runs free: both pins still closed, count moves
    wr(IDX_MODE, 8'h60);
    start_t();
    tick(1);
    expect_count(16'h0002);
    expect_run(1'b1);
    stop_t();
    test_done();
  end
endmodule
